// [inc/brs_pkg.sv]
// Purpose: constants for the battery backed clock SRAM block
// Assumes: 25 MHz system clock, 32768 Hz oscillator tick input
// Notes: clock window sits in the top eight bytes of the array
package brs_pkg;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam logic [12:0] OFS_CONTROL = 13'h1ff8;
  localparam logic [12:0] OFS_SECONDS = 13'h1ff9;
  localparam logic [12:0] OFS_MINUTES = 13'h1ffa;
  localparam logic [12:0] OFS_HOURS = 13'h1ffb;
  localparam logic [12:0] OFS_WEEKDAY = 13'h1ffc;
  localparam logic [12:0] OFS_DATE = 13'h1ffd;
  localparam logic [12:0] OFS_MONTH = 13'h1ffe;
  localparam logic [12:0] OFS_YEAR = 13'h1fff;
  // Control byte fields, seconds halt bit and weekday test bit
  localparam int CTL_WRITE_BIT = 7;
  localparam int CTL_READ_BIT = 6;
  localparam int CTL_SIGN_BIT = 5;
  localparam int SEC_HALT_BIT = 7;
  localparam int DAY_FT_BIT = 6;
  // Field masks for bits that must read as written zero
  localparam logic [7:0] MASK_SEC = 8'h7f;
  localparam logic [7:0] MASK_MIN = 8'h7f;
  localparam logic [7:0] MASK_HOUR = 8'h3f;
  localparam logic [7:0] MASK_DAY = 8'h07;
  localparam logic [7:0] MASK_DATE = 8'h3f;
  localparam logic [7:0] MASK_MONTH = 8'h1f;
  localparam logic [7:0] MASK_YEAR = 8'hff;
  // BCD limits
  localparam logic [7:0] BCD_SEC_MAX = 8'h59;
  localparam logic [7:0] BCD_HOUR_MAX = 8'h23;
  localparam logic [7:0] BCD_DAY_MAX = 8'h07;
  localparam logic [7:0] BCD_DATE_MAX = 8'h31;
  localparam logic [7:0] BCD_MONTH_MAX = 8'h12;
  localparam logic [7:0] BCD_YEAR_MAX = 8'h99;
  localparam logic [7:0] BCD_ZERO = 8'h00;
  localparam logic [7:0] BCD_ONE = 8'h01;
  // Divider chain in oscillator ticks
  localparam int OSC_HZ = 32768;
  localparam logic [15:0] OSC_SEC_LAST = 16'(OSC_HZ - 1);
  localparam logic [15:0] CAL_SHORTEN = 16'd128;
  localparam logic [15:0] CAL_LENGTHEN = 16'd256;
  localparam int FT_HALF_TICKS = OSC_HZ / (2 * 512);
  localparam logic [5:0] MIN_PER_CAL = 6'h3f;
  // Deselect delay after the power fail trip, 10 to 40 us
  localparam int SYS_CLK_HZ = 25_000_000;
  localparam int DESEL_US = 10;
  localparam int DESEL_CYC = (DESEL_US * SYS_CLK_HZ + 999_999) / 1_000_000;
  localparam int RECOVERY_US = 200;
  localparam int RECOVERY_CYC = (RECOVERY_US * (SYS_CLK_HZ / 1_000_000));
  typedef enum logic [1:0] {BRS_RUN, BRS_TRIP, BRS_DESEL, BRS_RECOV}
    brs_pwr_t;
endpackage : brs_pkg

// [rtl/brs_core.sv]
// Purpose: clock, calibration and power fail logic of a backed clock SRAM
// Assumes: supply comparators arrive as synchronous levels; osc_tick pulses
//   once per 32768 Hz oscillator edge
// Notes: the 8K array is modelled here; data pins are split in/out/enable
// Operation
// RULE1: Inside the fail window deselect, block writes, float data, ignore inputs.
// RULE2: A power loss mid write may only hit the addressed byte.
// RULE3: Below switch threshold run from battery, back on supply above it.
// RULE4: After power returns, keep writes blocked for the recovery time.
// RULE5: Host holds chip enables inactive while supply rises through threshold.
// RULE6: At trip raise interrupt at once, deselect after a timed delay.
// RULE7: Interrupt is open drain pulling low only, board adds pull up.
// RULE8: Software halts updates before reading clock bytes.
// RULE9: Read latch bit freezes register copies; counters keep running.
// RULE10: All registers update together; halt never cuts an update; resume.
// RULE11: Set latch halts updates; clearing loads counters from the bytes.
// RULE12: Time bytes are packed BCD, 24 hour, with stated ranges.
// RULE13: Software writes zero to test bit and zero marked bits.
// RULE14: Seconds top bit halts the oscillator; zero restarts it.
// RULE15: Software toggles halt bit once after first power up.
// RULE16: Control low five bits give magnitude, sixth bit sign.
// RULE17: Calibration adds or removes counts at the divide by 256 stage.
// RULE18: Over 64 minutes, first 2N minutes adjust one second each.
// RULE19: With test bit set and oscillator running, seconds bit 0 toggles; the code toggles it only while the read bit is clear.
// RULE20: Calibration changes never affect the test output.
// RULE21: Host holds a stable read of seconds to watch test output.
// RULE22: One second tick advances BCD counters with carries and wraps.
module brs_core
  import brs_pkg::*;
#(
  parameter int RECOVERY_CYCLES = RECOVERY_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Supply monitor levels
  input wire logic supply_below_pf,
  input wire logic supply_below_switch,
  // Oscillator
  input wire logic osc_tick,
  // SRAM bus
  input wire logic [brs_pkg::ADDR_W-1:0] addr,
  input wire logic chip_select_low_active_n,
  input wire logic chip_select_high_active,
  input wire logic out_en_n,
  input wire logic write_en_n,
  input wire logic [brs_pkg::DATA_W-1:0] data_in,
  output logic [brs_pkg::DATA_W-1:0] data_out,
  output logic data_oe,
  // Power status
  output logic int_fail_out,
  output logic int_fail_oe,
  output logic on_battery
);
  import brs_pkg::*;

  logic [7:0] mem [0:8183];
  logic [7:0] ctl, r_sec, r_min, r_hour, r_day, r_date, r_mon, r_year;
  logic [7:0] c_sec, c_min, c_hour, c_day, c_date, c_mon, c_year;
  logic [15:0] div_cnt;
  logic [5:0] cal_min;
  logic ft_bit;
  // Test square wave flips every FT_HALF_TICKS oscillator ticks
  // Bit FT_MSB of a free counter gives that half period directly
  localparam int FT_MSB = $clog2(FT_HALF_TICKS);
  logic [5:0] ft_cnt;
  brs_pwr_t pwr;
  logic [15:0] pwr_cnt;
  // Write strobe of the previous cycle, for the closing edge
  logic wr_q;

  // BCD increment with wrap back to a floor value
  function automatic logic [7:0] bcd_inc(input logic [7:0] v,
      input logic [7:0] vmax, input logic [7:0] vmin);
    logic [7:0] r;
    r = v;
    if (v >= vmax) r = vmin;
    else if (v[3:0] == 4'h9) r = {v[7:4] + 4'h1, 4'h0};
    else r = {v[7:4], v[3:0] + 4'h1};
    return r;
  endfunction : bcd_inc

  // Power state machine: trip, delayed deselect, recovery
  brs_pwr_t next_pwr;
  logic [15:0] next_pwr_cnt;
  always_comb begin
    next_pwr = pwr;
    next_pwr_cnt = pwr_cnt;
    unique case (pwr)
      BRS_RUN: if (supply_below_pf) begin
        next_pwr = BRS_TRIP; // RULE6
        next_pwr_cnt = 16'h0000;
      end
      BRS_TRIP: begin
        next_pwr_cnt = pwr_cnt + 16'h0001;
        if (pwr_cnt == 16'(DESEL_CYC - 1)) next_pwr = BRS_DESEL; // RULE6
      end
      BRS_DESEL: if (!supply_below_pf) begin
        next_pwr = BRS_RECOV; // RULE4
        next_pwr_cnt = 16'h0000;
      end
      BRS_RECOV: begin
        next_pwr_cnt = pwr_cnt + 16'h0001;
        if (supply_below_pf) next_pwr = BRS_DESEL;
        else if (pwr_cnt == 16'(RECOVERY_CYCLES - 1)) next_pwr = BRS_RUN;
      end
    endcase
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pwr <= BRS_RECOV;
      pwr_cnt <= 16'h0000;
    end else begin
      pwr <= next_pwr;
      pwr_cnt <= next_pwr_cnt;
    end
  end

  // Bus decode; inputs ignored unless powered and recovered
  logic powered, sel, wr, rd, win;
  assign powered = (pwr == BRS_RUN) || (pwr == BRS_TRIP); // RULE1 RULE4
  assign sel = powered && !chip_select_low_active_n && chip_select_high_active;
  assign wr = sel && !write_en_n;
  assign rd = sel && !out_en_n && write_en_n;
  assign win = (addr >= OFS_CONTROL);
  // Write commits only on its closing edge, so a cut write touches one byte
  logic wr_commit;
  assign wr_commit = wr_q && !wr; // RULE2

  // Counter chain with calibration and one second tick
  logic [15:0] sec_len, next_div;
  logic sec_tick, ctl_w_fall, ft_on;
  assign ctl_w_fall = wr_commit && (addr == OFS_CONTROL) &&
    ctl[CTL_WRITE_BIT] && !data_in[CTL_WRITE_BIT];
  assign ft_on = ft_bit && !c_sec[SEC_HALT_BIT];
  always_comb begin
    sec_len = OSC_SEC_LAST;
    if ({1'b0, cal_min} < {1'b0, ctl[4:0], 1'b0} && c_sec == BCD_ZERO) begin
      if (ctl[CTL_SIGN_BIT]) sec_len = OSC_SEC_LAST - CAL_SHORTEN; // RULE17 RULE18
      else sec_len = OSC_SEC_LAST + CAL_LENGTHEN; // RULE16
    end
    sec_tick = osc_tick && !c_sec[SEC_HALT_BIT] && div_cnt >= sec_len; // RULE14
    next_div = osc_tick && !c_sec[SEC_HALT_BIT] ?
      (sec_tick ? 16'h0000 : div_cnt + 16'h0001) : div_cnt;
  end

  // Live counters and register copies
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      {c_sec, c_min, c_hour} <= '0;
      {c_day, c_date, c_mon} <= {BCD_ONE, BCD_ONE, BCD_ONE};
      c_year <= BCD_ZERO;
      {r_sec, r_min, r_hour, r_year} <= '0;
      {r_day, r_date, r_mon} <= {BCD_ONE, BCD_ONE, BCD_ONE};
      ctl <= 8'h00;
      ft_bit <= 1'b0;
      div_cnt <= 16'h0000;
      cal_min <= 6'h00;
      ft_cnt <= 6'h00;
      wr_q <= 1'b0;
    end else begin
      wr_q <= wr;
      div_cnt <= next_div;
      if (osc_tick) ft_cnt <= ft_cnt + 6'h01; // RULE20
      if (ctl_w_fall) begin
        // Load counters from register bytes // RULE11
        // Halt bit travels with the load, so a stop stays a stop
        c_sec <= r_sec; // RULE14
        c_min <= r_min;
        c_hour <= r_hour;
        c_day <= r_day;
        c_date <= r_date;
        c_mon <= r_mon;
        c_year <= r_year;
        div_cnt <= 16'h0000;
      end else if (sec_tick) begin
        // BCD carry chain // RULE22 RULE12
        c_sec <= bcd_inc(c_sec, BCD_SEC_MAX, BCD_ZERO);
        if (c_sec == BCD_SEC_MAX) begin
          c_min <= bcd_inc(c_min, BCD_SEC_MAX, BCD_ZERO);
          cal_min <= (cal_min == MIN_PER_CAL) ? 6'h00 : cal_min + 6'h01;
          if (c_min == BCD_SEC_MAX) begin
            c_hour <= bcd_inc(c_hour, BCD_HOUR_MAX, BCD_ZERO);
            if (c_hour == BCD_HOUR_MAX) begin
              c_day <= bcd_inc(c_day, BCD_DAY_MAX, BCD_ONE);
              c_date <= bcd_inc(c_date, BCD_DATE_MAX, BCD_ONE);
              if (c_date == BCD_DATE_MAX) begin
                c_mon <= bcd_inc(c_mon, BCD_MONTH_MAX, BCD_ONE);
                if (c_mon == BCD_MONTH_MAX)
                  c_year <= bcd_inc(c_year, BCD_YEAR_MAX, BCD_ZERO);
              end
            end
          end
        end
      end
      // Copies follow counters as a group unless halted // RULE9 RULE10
      if (!ctl[CTL_READ_BIT] && !ctl[CTL_WRITE_BIT] && !ctl_w_fall) begin
        r_sec <= {r_sec[SEC_HALT_BIT], c_sec[6:0]};
        r_min <= c_min;
        r_hour <= c_hour;
        r_day <= c_day;
        r_date <= c_date;
        r_mon <= c_mon;
        r_year <= c_year;
      end
      if (wr_commit && win) begin
        unique case (addr)
          OFS_CONTROL: ctl <= data_in; // RULE11 RULE16
          OFS_SECONDS: begin
            r_sec <= data_in;
            c_sec[SEC_HALT_BIT] <= data_in[SEC_HALT_BIT]; // RULE14
          end
          OFS_MINUTES: r_min <= data_in & MASK_MIN;
          OFS_HOURS: r_hour <= data_in & MASK_HOUR;
          OFS_WEEKDAY: begin
            r_day <= data_in & MASK_DAY;
            ft_bit <= data_in[DAY_FT_BIT]; // RULE19
          end
          OFS_DATE: r_date <= data_in & MASK_DATE;
          OFS_MONTH: r_mon <= data_in & MASK_MONTH;
          default: r_year <= data_in & MASK_YEAR;
        endcase
      end
    end
  end

  // Plain SRAM below the clock window
  always_ff @(posedge clk_sys) begin
    if (wr_commit && !win) mem[addr] <= data_in; // RULE2
  end

  // Read data and pin drivers, all registered
  logic [7:0] next_dout;
  always_comb begin
    unique case (addr)
      OFS_CONTROL: next_dout = ctl;
      OFS_SECONDS: next_dout = (ft_on && !ctl[CTL_READ_BIT]) ?
        {r_sec[7:1], ft_cnt[FT_MSB]} : r_sec; // RULE19
      OFS_MINUTES: next_dout = r_min;
      OFS_HOURS: next_dout = r_hour;
      OFS_WEEKDAY: next_dout = {1'b0, ft_bit, r_day[5:0]};
      OFS_DATE: next_dout = r_date;
      OFS_MONTH: next_dout = r_mon;
      OFS_YEAR: next_dout = r_year;
      default: next_dout = mem[addr];
    endcase
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      data_out <= 8'h00;
      data_oe <= 1'b0;
      int_fail_out <= 1'b0;
      int_fail_oe <= 1'b0;
      on_battery <= 1'b0;
    end else begin
      data_out <= next_dout;
      data_oe <= rd; // RULE1
      int_fail_oe <= next_pwr != BRS_RUN; // RULE6 RULE7
      on_battery <= supply_below_switch; // RULE3
    end
  end

  AST_FLOAT: assert property (@(posedge clk_sys) disable iff (!resetn)
    pwr == BRS_DESEL |=> !data_oe) else $error("data driven while off"); // RULE1
  AST_INT: assert property (@(posedge clk_sys) disable iff (!resetn)
    pwr == BRS_RUN && supply_below_pf |=> int_fail_oe)
    else $error("interrupt late"); // RULE6
  AST_OD: assert property (@(posedge clk_sys) disable iff (!resetn)
    !int_fail_out) else $error("interrupt driven high"); // RULE7
  AST_BATT: assert property (@(posedge clk_sys) disable iff (!resetn)
    supply_below_switch |=> on_battery) else $error("no battery"); // RULE3
  AST_FREEZE: assert property (@(posedge clk_sys) disable iff (!resetn)
    ctl[CTL_READ_BIT] && $stable(ctl) && !wr_commit |=> $stable(r_min))
    else $error("copy moved while frozen"); // RULE9
  AST_STOP: assert property (@(posedge clk_sys) disable iff (!resetn)
    c_sec[SEC_HALT_BIT] |-> !sec_tick) else $error("ticked while stopped"); // RULE14
  AST_LOAD: assert property (@(posedge clk_sys) disable iff (!resetn)
    ctl_w_fall |=> c_min == $past(r_min)) else $error("no load"); // RULE11
  AST_SEC: assert property (@(posedge clk_sys) disable iff (!resetn)
    (c_sec & MASK_SEC) <= BCD_SEC_MAX)
    else $error("seconds out of range"); // RULE12
  AST_MIN: assert property (@(posedge clk_sys) disable iff (!resetn)
    c_min <= BCD_SEC_MAX) else $error("minutes out of range"); // RULE12
  AST_HOUR: assert property (@(posedge clk_sys) disable iff (!resetn)
    c_hour <= BCD_HOUR_MAX) else $error("hours out of range"); // RULE12
  // A second cycle in deselect can only commit a write if gating leaks
  AST_WPROT: assert property (@(posedge clk_sys) disable iff (!resetn)
    pwr == BRS_DESEL && $past(pwr == BRS_DESEL) |-> !wr_commit)
    else $error("write while deselected"); // RULE1
  AST_SUPPLY: assert property (@(posedge clk_sys) disable iff (!resetn)
    !supply_below_switch |=> !on_battery)
    else $error("stuck on battery"); // RULE3
  AST_NOCAL: assert property (@(posedge clk_sys) disable iff (!resetn)
    ctl[4:0] == 5'h00 |-> sec_len == OSC_SEC_LAST)
    else $error("second adjusted without calibration"); // RULE18
  AST_RECOV: assert property (@(posedge clk_sys) disable iff (!resetn)
    pwr == BRS_DESEL ##1 pwr == BRS_RECOV |-> !sel [*4])
    else $error("access during recovery"); // RULE4
  COV_TRIP: cover property (@(posedge clk_sys) pwr == BRS_DESEL);
  COV_LOAD: cover property (@(posedge clk_sys) ctl_w_fall);
  COV_TICK: cover property (@(posedge clk_sys) sec_tick);
  // Test output enabled during a bus read at any address, and a calibrated second
  COV_FT: cover property (@(posedge clk_sys) ft_on && rd);
  COV_CAL: cover property (@(posedge clk_sys)
    sec_tick && sec_len != OSC_SEC_LAST);
endmodule : brs_core

// [test/brs_host.sv]
// Purpose: host processor model on the byte wide clock SRAM bus
// Assumes: bus levels change only at the falling clock edge
// Notes: released write data shows the inverse of the last byte
module brs_host
  import brs_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Bus towards the block
  output logic [brs_pkg::ADDR_W-1:0] addr,
  output logic cs_n,
  output logic cs_hi,
  output logic oe_n,
  output logic we_n,
  output logic [brs_pkg::DATA_W-1:0] wdata,
  // Read return
  input wire logic [brs_pkg::DATA_W-1:0] rdata_in,
  input wire logic oe_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // Selects idle until the supply is trusted, no stray writes
  initial begin
    addr = 13'h0000;
    cs_n = 1'b1;
    cs_hi = 1'b0;
    oe_n = 1'b1;
    we_n = 1'b1;
    wdata = 8'h00;
  end

  // Both selects move together
  task automatic sel(input logic on);
    cs_n = ~on;
    cs_hi = on;
  endtask : sel

  // Strobe one cycle, hold address and data a cycle more, then idle
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    addr = a;
    wdata = d;
    sel(1'b1);
    we_n = 1'b0;
    @(negedge clk_sys);
    we_n = 1'b1;
    @(negedge clk_sys);
    sel(1'b0);
    wdata = ~d;
    @(negedge clk_sys);
  endtask : wr

  // Read answered a cycle after the request, sampled when settled
  task automatic rd(input logic [12:0] a, output logic [7:0] d,
                    output logic oe);
    @(negedge clk_sys);
    addr = a;
    sel(1'b1);
    oe_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    d = rdata_in;
    oe = oe_in;
    oe_n = 1'b1;
    sel(1'b0);
  endtask : rd

  // Long read of seconds, counting bit 0 transitions
  task automatic watch(input int n, output int t);
    logic last;
    t = 0;
    @(negedge clk_sys);
    addr = OFS_SECONDS;
    sel(1'b1);
    oe_n = 1'b0;
    repeat (3) @(negedge clk_sys);
    last = rdata_in[0];
    repeat (n) begin
      @(negedge clk_sys);
      if (rdata_in[0] !== last) t++;
      last = rdata_in[0];
    end
    oe_n = 1'b1;
    sel(1'b0);
  endtask : watch
endmodule : brs_host

// [test/brs_core_bench.sv]
// Purpose: self checking bench for the clock SRAM core
// Assumes: one oscillator tick every second system clock
// Notes: recovery shortened to 8 cycles; one clock second takes 65536 system clocks
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH %0t got %h exp %h", $time, (g), (e)); end end
`define WAITC(c, n) begin k = 0; while (!(c) && k < (n)) begin \
  @(negedge clk_sys); k++; end if (!(c)) begin n_errors++; \
  $display("MISMATCH %0t wait ran out", $time); end_sim(); end end
module brs_core_bench
  import brs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, resetn, below_pf, below_sw, osc_tick;
  logic [12:0] addr;
  logic cs_n, cs_hi, oe_n, we_n, data_oe, int_out, int_oe, on_bat, ok;
  logic [7:0] wdata, data_out, rdata;
  logic [7:0] tset [7] = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99};
  logic [7:0] texp [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
  int n_errors = 0;
  int n_checks = 0;
  int k, t0;

  // 25 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Oscillator ticks every other cycle to keep a second short
  always @(negedge clk_sys) osc_tick <= ~osc_tick;

  brs_host u_host (.clk_sys(clk_sys), .addr(addr), .cs_n(cs_n),
    .cs_hi(cs_hi), .oe_n(oe_n), .we_n(we_n), .wdata(wdata),
    .rdata_in(data_out), .oe_in(data_oe));
  brs_core #(.RECOVERY_CYCLES(8)) u_dut (.clk_sys(clk_sys),
    .resetn(resetn), .supply_below_pf(below_pf),
    .supply_below_switch(below_sw), .osc_tick(osc_tick), .addr(addr),
    .chip_select_low_active_n(cs_n), .chip_select_high_active(cs_hi),
    .out_en_n(oe_n), .write_en_n(we_n), .data_in(wdata),
    .data_out(data_out), .data_oe(data_oe), .int_fail_out(int_out),
    .int_fail_oe(int_oe), .on_battery(on_bat));

  // Counts, verdict and stop
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  initial begin
    resetn = 1'b0;
    below_pf = 1'b0;
    below_sw = 1'b0;
    osc_tick = 1'b0;
    repeat (12) @(negedge clk_sys);
    resetn = 1'b1;
    repeat (12) @(negedge clk_sys);
    // Plain bytes at both ends of the array
    u_host.wr(13'h0000, 8'h11);
    u_host.wr(13'h1ff7, 8'hc3);
    u_host.rd(13'h0000, rdata, ok);
    `CHK(rdata, 8'h11)
    u_host.rd(13'h1ff7, rdata, ok);
    `CHK(rdata, 8'hc3)
    u_host.wr(OFS_CONTROL, 8'h3f);
    u_host.rd(OFS_CONTROL, rdata, ok);
    `CHK(rdata, 8'h3f)
    // Last second of a year, every field must roll over
    u_host.wr(OFS_CONTROL, 8'h80);
    u_host.wr(OFS_SECONDS, 8'hd9);
    foreach (tset[i]) u_host.wr(OFS_SECONDS + 13'(i), tset[i]);
    u_host.wr(OFS_CONTROL, 8'h00);
    k = 0;
    do begin
      u_host.rd(OFS_SECONDS, rdata, ok);
      k++;
    end while (rdata === 8'h59 && k < 23000);
    `CHK(rdata === 8'h59, 1'b0)
    u_host.wr(OFS_CONTROL, 8'h40);
    foreach (texp[i]) begin
      u_host.rd(OFS_SECONDS + 13'(i), rdata, ok);
      `CHK(rdata, texp[i])
    end
    // Test output, unchanged by calibration, still when halted
    u_host.wr(OFS_CONTROL, 8'h80);
    u_host.wr(OFS_WEEKDAY, 8'h41);
    u_host.wr(OFS_CONTROL, 8'h00);
    u_host.watch(1024, t0);
    `CHK(t0 inside {[15:17]}, 1'b1)
    u_host.wr(OFS_CONTROL, 8'h3f);
    u_host.watch(1024, t0);
    `CHK(t0 inside {[15:17]}, 1'b1)
    u_host.wr(OFS_CONTROL, 8'hbf);
    u_host.wr(OFS_SECONDS, 8'h80);
    u_host.wr(OFS_CONTROL, 8'h3f);
    u_host.watch(1024, t0);
    `CHK(t0, 0)
    u_host.wr(OFS_CONTROL, 8'h80);
    u_host.wr(OFS_SECONDS, 8'h00);
    u_host.wr(OFS_WEEKDAY, 8'h01);
    u_host.wr(OFS_CONTROL, 8'h00);
    // Supply fault: alarm at once, deselect after the timed delay
    below_pf = 1'b1;
    `WAITC(int_oe === 1'b1, 2)
    `CHK(int_out, 1'b0)
    u_host.rd(13'h0000, rdata, ok);
    `CHK(ok, 1'b1)
    repeat (260) @(negedge clk_sys);
    u_host.wr(13'h0000, 8'h99);
    u_host.rd(13'h0000, rdata, ok);
    `CHK(ok, 1'b0)
    below_sw = 1'b1;
    `WAITC(on_bat === 1'b1, 4)
    below_sw = 1'b0;
    `WAITC(on_bat === 1'b0, 4)
    below_pf = 1'b0;
    u_host.wr(13'h0000, 8'h22);
    repeat (12) @(negedge clk_sys);
    u_host.rd(13'h0000, rdata, ok);
    `CHK(rdata, 8'h11)
    end_sim();
  end
endmodule : brs_core_bench
